/* File: rtl/sli_pkg.sv */
// Purpose: Shared constants for the status indicator light block.
// Assumes: 50 MHz mclk; TICK_US is in microseconds, the other times below in milliseconds of the 1 ms tick.
// Notes: Register addresses are word indexes on the plain register port.
package sli_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int ON_MS = 200;
    localparam int OFF_MS = 300;
    localparam int PAUSE_MS = 1500;
    localparam int FLASH_MS = 100;
    localparam int FW_MS = 250;
    localparam int SPD_BASE_MS = 500;
    localparam int SPD_MIN_MS = 25;
    localparam int SPD_SHIFT = 6;

    // ==========================================================
    // Register map
    localparam logic [3:0] ADDR_ERR_EN = 4'h0;
    localparam logic [3:0] ADDR_ERR_STAT = 4'h1;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h4;
    localparam logic [15:0] ERR_EN_RST = 16'h0000;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;

    // Field positions
    localparam int ERR_STAT_ACT = 15;
    localparam int ERR_STAT_FW = 14;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_MODE = 1;
    localparam int IRQ_NVW = 2;
    localparam int IRQ_FW = 3;

    // ==========================================================
    // Error blink sequencer states
    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_ON = 2'b01,
        SQ_OFF = 2'b11,
        SQ_PAUSE = 2'b10
    } sli_seq_e;

endpackage : sli_pkg

/* File: rtl/sli_tick.sv */
// Purpose: Divides mclk down to a one-cycle 1 ms enable pulse.
// Assumes: DIV fits in 16 bits.
// Notes: All slow timing in the block counts these pulses.
module sli_tick #(
    parameter int DIV = sli_pkg::TICK_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    output logic tick
);

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic tick_next;

    // ==========================================================
    // Divider
    always_comb begin
        tick_next = (cnt_reg == 16'(DIV - 1));
        cnt_next = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end

endmodule : sli_tick

/* File: rtl/sli_blink_seq.sv */
// Purpose: Plays a burst of N blinks followed by a pause, repeating.
// Assumes: count is held stable while run is high.
// Notes: Dropping run returns to idle at once, so a cleared error ends the burst.
module sli_blink_seq #(
    parameter int ON_T = sli_pkg::ON_MS,
    parameter int OFF_T = sli_pkg::OFF_MS,
    parameter int PAUSE_T = sli_pkg::PAUSE_MS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [4:0] count,
    output logic blink
);

    sli_pkg::sli_seq_e st_reg, st_next;
    logic [11:0] tmr_reg, tmr_next;
    logic [4:0] left_reg, left_next;

    // ==========================================================
    // Sequencer: ON/OFF pairs until the count is used, then a pause
    always_comb begin
        st_next = st_reg;
        tmr_next = tmr_reg;
        left_next = left_reg;
        if (!run) begin
            st_next = sli_pkg::SQ_IDLE;
        end else if (tick) begin
            tmr_next = tmr_reg + 12'h001;
            unique case (st_reg)
                sli_pkg::SQ_IDLE: begin
                    st_next = sli_pkg::SQ_ON;
                    tmr_next = 12'h000;
                    left_next = count;
                end
                sli_pkg::SQ_ON: begin
                    if (tmr_reg >= 12'(ON_T - 1)) begin
                        tmr_next = 12'h000;
                        left_next = left_reg - 5'h01;
                        st_next = (left_reg == 5'h01) ? sli_pkg::SQ_PAUSE : sli_pkg::SQ_OFF;
                    end
                end
                sli_pkg::SQ_OFF: begin
                    if (tmr_reg >= 12'(OFF_T - 1)) begin
                        tmr_next = 12'h000;
                        st_next = sli_pkg::SQ_ON;
                    end
                end
                sli_pkg::SQ_PAUSE: begin
                    if (tmr_reg >= 12'(PAUSE_T - 1)) begin
                        st_next = sli_pkg::SQ_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= sli_pkg::SQ_IDLE;
            tmr_reg <= 12'h000;
            left_reg <= 5'h00;
            blink <= 1'b0;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            left_reg <= left_next;
            blink <= (st_next == sli_pkg::SQ_ON);
        end
    end

endmodule : sli_blink_seq

/* File: rtl/sli_status_led.sv */
// Purpose: Drives the green/red indicator from motor state and status bits.
// Assumes: All motor inputs come from logic on mclk; no synchronisers needed.
// Notes: Registers sit on a plain port; read data appears the cycle after rd.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module sli_status_led #(
    parameter int TICK_CYC = sli_pkg::TICK_CYC,
    parameter int ON_T = sli_pkg::ON_MS,
    parameter int OFF_T = sli_pkg::OFF_MS,
    parameter int PAUSE_T = sli_pkg::PAUSE_MS,
    parameter int FLASH_T = sli_pkg::FLASH_MS,
    parameter int FW_T = sli_pkg::FW_MS,
    parameter int SPD_BASE = sli_pkg::SPD_BASE_MS,
    parameter int SPD_MIN = sli_pkg::SPD_MIN_MS,
    parameter int SPD_SHIFT = sli_pkg::SPD_SHIFT
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic irq,
    input wire logic motor_on,
    input wire logic [15:0] speed,
    input wire logic [15:0] torque,
    input wire logic [7:0] mode,
    input wire logic nv_write,
    input wire logic fw_mode,
    input wire logic fw_done,
    input wire logic [15:0] status_bits,
    output logic led_green,
    output logic led_red
);

    logic tick;
    logic err_blink;

    // Register state
    logic [15:0] err_en_reg, err_en_next;
    logic [3:0] irq_stat_reg, irq_stat_next;
    logic [3:0] irq_en_reg, irq_en_next;
    logic [15:0] rdata_next;

    // Motor state tracking
    logic [7:0] mode_prev_reg;
    logic primed_reg;
    logic err_reg, err_next;
    logic [4:0] cause_reg, cause_next;
    logic fw_reg, fw_next;
    logic [11:0] flash_reg, flash_next;
    logic [11:0] mot_cnt_reg, mot_cnt_next;
    logic mot_ph_reg, mot_ph_next;
    logic [11:0] fw_cnt_reg, fw_cnt_next;
    logic fw_ph_reg, fw_ph_next;
    logic [7:0] pwm_reg;

    logic [15:0] err_hits;
    logic mode_chg;
    logic err_rise;
    logic fw_rise;
    logic [15:0] spd_scaled;
    logic [11:0] half_per;
    logic moving;
    logic torque_red;
    logic green_next, red_next;
    logic [4:0] low_idx;

    // ==========================================================
    // Time base and error burst player
    sli_tick #(
        .DIV(TICK_CYC)
    ) u_tick (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick)
    );

    sli_blink_seq #(
        .ON_T(ON_T),
        .OFF_T(OFF_T),
        .PAUSE_T(PAUSE_T)
    ) u_seq (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick(tick),
        .run(err_reg),
        .count(cause_reg),
        .blink(err_blink)
    );

    // ==========================================================
    // Error detection
    // Only bits enabled in the error enable register may force error state
    always_comb begin
        err_hits = status_bits & err_en_reg;
        err_next = |err_hits;
        err_rise = err_next & ~err_reg;
        // Lowest bit wins so the count is stable when several bits fire
        low_idx = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (err_hits[i]) begin
                low_idx = 5'(i);
            end
        end
        // Bit n reports as n+1 blinks, covering every cause code
        cause_next = err_rise ? low_idx + 5'h01 : cause_reg;
    end

    // ==========================================================
    // Events: mode change, store write, firmware entry
    always_comb begin
        mode_chg = primed_reg && (mode != mode_prev_reg);
        fw_rise = fw_mode & ~fw_reg;
        // Firmware state holds until the upgrade completes or reset
        fw_next = fw_reg;
        if (fw_mode) begin
            fw_next = 1'b1;
        end else if (fw_done) begin
            fw_next = 1'b0;
        end
        // A mode change or store write restarts the flash rather than queueing another
        flash_next = flash_reg;
        if (mode_chg || nv_write) begin
            flash_next = 12'(FLASH_T);
        end else if (tick && flash_reg != 12'h000) begin
            flash_next = flash_reg - 12'h001;
        end
    end

    // ==========================================================
    // Motion blink rate and torque colour mix
    always_comb begin
        moving = motor_on && (speed != 16'h0000 || torque != 16'h0000);
        // Half period shrinks with speed, floored so the blink stays visible
        spd_scaled = speed >> SPD_SHIFT;
        if (spd_scaled >= 16'(SPD_BASE - SPD_MIN)) begin
            half_per = 12'(SPD_MIN);
        end else begin
            half_per = 12'(SPD_BASE) - spd_scaled[11:0];
        end
        mot_cnt_next = mot_cnt_reg;
        mot_ph_next = mot_ph_reg;
        if (!moving) begin
            mot_cnt_next = 12'h000;
            mot_ph_next = 1'b1;
        end else if (tick) begin
            if (mot_cnt_reg + 12'h001 >= half_per) begin
                mot_cnt_next = 12'h000;
                mot_ph_next = ~mot_ph_reg;
            end else begin
                mot_cnt_next = mot_cnt_reg + 12'h001;
            end
        end
        // Red share of each lit period follows the torque high byte
        torque_red = (torque[15:8] > pwm_reg);
        fw_cnt_next = fw_cnt_reg;
        fw_ph_next = fw_ph_reg;
        if (!fw_reg) begin
            fw_cnt_next = 12'h000;
            fw_ph_next = 1'b0;
        end else if (tick) begin
            if (fw_cnt_reg >= 12'(FW_T - 1)) begin
                fw_cnt_next = 12'h000;
                fw_ph_next = ~fw_ph_reg;
            end else begin
                fw_cnt_next = fw_cnt_reg + 12'h001;
            end
        end
    end

    // ==========================================================
    // Indicator selection, firmware over error over flash over motion
    always_comb begin
        if (fw_reg) begin
            green_next = ~fw_ph_reg;
            red_next = fw_ph_reg;
        end else if (err_reg) begin
            // Red stays lit; each blink adds green to read as yellow
            green_next = err_blink;
            red_next = 1'b1;
        end else if (flash_reg != 12'h000) begin
            green_next = 1'b0;
            red_next = 1'b1;
        end else if (moving) begin
            green_next = mot_ph_reg & ~torque_red;
            red_next = mot_ph_reg & torque_red;
        end else begin
            green_next = 1'b1;
            red_next = 1'b0;
        end
    end

    // ==========================================================
    // Register port and interrupt status
    always_comb begin
        err_en_next = err_en_reg;
        irq_en_next = irq_en_reg;
        irq_stat_next = irq_stat_reg;
        if (wr && addr == sli_pkg::ADDR_ERR_EN) begin
            err_en_next = wdata;
        end
        if (wr && addr == sli_pkg::ADDR_IRQ_EN) begin
            irq_en_next = wdata[3:0];
        end
        if (wr && addr == sli_pkg::ADDR_IRQ_CLR) begin
            irq_stat_next = irq_stat_reg & ~wdata[3:0];
        end
        // Sets come after the clear so a same-cycle event is kept
        if (err_rise) irq_stat_next[sli_pkg::IRQ_ERR] = 1'b1;
        if (mode_chg) irq_stat_next[sli_pkg::IRQ_MODE] = 1'b1;
        if (nv_write) irq_stat_next[sli_pkg::IRQ_NVW] = 1'b1;
        if (fw_rise) irq_stat_next[sli_pkg::IRQ_FW] = 1'b1;
        rdata_next = 16'h0000;
        if (rd) begin
            unique case (addr)
                sli_pkg::ADDR_ERR_EN: rdata_next = err_en_reg;
                sli_pkg::ADDR_ERR_STAT: begin
                    rdata_next[sli_pkg::ERR_STAT_ACT] = err_reg;
                    rdata_next[sli_pkg::ERR_STAT_FW] = fw_reg;
                    rdata_next[4:0] = cause_reg;
                end
                sli_pkg::ADDR_IRQ_STAT: rdata_next[3:0] = irq_stat_reg;
                sli_pkg::ADDR_IRQ_EN: rdata_next[3:0] = irq_en_reg;
                default: rdata_next = 16'h0000; // Unmapped and write-only read zero
            endcase
        end
    end

    // ==========================================================
    // State registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_en_reg <= sli_pkg::ERR_EN_RST;
            irq_en_reg <= sli_pkg::IRQ_EN_RST;
            irq_stat_reg <= 4'h0;
            rdata <= 16'h0000;
            irq <= 1'b0;
            mode_prev_reg <= 8'h00;
            primed_reg <= 1'b0;
            err_reg <= 1'b0;
            cause_reg <= 5'h00;
            fw_reg <= 1'b0;
            flash_reg <= 12'h000;
            mot_cnt_reg <= 12'h000;
            mot_ph_reg <= 1'b1;
            fw_cnt_reg <= 12'h000;
            fw_ph_reg <= 1'b0;
            pwm_reg <= 8'h00;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end else begin
            err_en_reg <= err_en_next;
            irq_en_reg <= irq_en_next;
            irq_stat_reg <= irq_stat_next;
            rdata <= rdata_next;
            irq <= |(irq_stat_next & irq_en_next);
            mode_prev_reg <= mode;
            primed_reg <= 1'b1; // First cycle only captures the mode
            err_reg <= err_next;
            cause_reg <= cause_next;
            fw_reg <= fw_next;
            flash_reg <= flash_next;
            mot_cnt_reg <= mot_cnt_next;
            mot_ph_reg <= mot_ph_next;
            fw_cnt_reg <= fw_cnt_next;
            fw_ph_reg <= fw_ph_next;
            pwm_reg <= pwm_reg + 8'h01;
            led_green <= green_next;
            led_red <= red_next;
        end
    end

endmodule : sli_status_led

/* File: test/sli_status_led_monitor.sv */
// Purpose: Port-level checks on the status indicator block.
// Assumes: Error enables are shadowed from bus writes seen at the port.
// Notes: The idle check waits out a whole flash before it applies.
module sli_status_led_monitor #(
    parameter int TICK_CYC = 10,
    parameter int FLASH_T = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic irq,
    input wire logic motor_on,
    input wire logic [7:0] mode,
    input wire logic nv_write,
    input wire logic fw_mode,
    input wire logic fw_done,
    input wire logic [15:0] status_bits,
    input wire logic led_green,
    input wire logic led_red
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Helper state
    localparam int QUIET = (FLASH_T + 2) * TICK_CYC;
    logic [15:0] en_reg, en_next, q_reg, q_next;
    logic [7:0] m_reg;
    logic err_on;
    // Shadow enables and count quiet idle cycles; any event restarts the count
    always_comb begin
        en_next = (wr && addr == sli_pkg::ADDR_ERR_EN) ? wdata : en_reg;
        err_on = |(status_bits & en_reg);
        q_next = (q_reg == 16'hffff) ? q_reg : q_reg + 16'h0001;
        if (motor_on || err_on || fw_mode || fw_done || nv_write || mode != m_reg) begin
            q_next = 16'h0000;
        end
    end
    // Register the helper state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= 16'h0000;
            q_reg <= 16'h0000;
            m_reg <= 8'h00;
        end else begin
            en_reg <= en_next;
            q_reg <= q_next;
            m_reg <= mode;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_err_live;
        (err_on && !fw_mode) [*3];
    endsequence
    sequence s_fw_held;
        fw_mode [*3];
    endsequence
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside answer cycle");
    a_irq_off: assert property (wr && addr == sli_pkg::ADDR_IRQ_EN && wdata[3:0] == 4'h0
        |-> ##[1:2] !irq)
        else $error("interrupt stays high with all enables off");
    a_mode_flash: assert property (mode != $past(mode) && !fw_mode |-> ##2 led_red)
        else $error("no red flash after mode change");
    a_nvw_flash: assert property (nv_write && !fw_mode |-> ##2 led_red)
        else $error("no red flash after store write");
    a_nvw_dark: assert property (nv_write && !fw_mode && !motor_on && !err_on
        |-> ##2 !led_green)
        else $error("green lit during idle flash");
    a_idle_green: assert property (int'(q_reg) >= QUIET |-> led_green && !led_red)
        else $error("idle light not steady green");
    a_err_red: assert property (s_err_live |-> led_red)
        else $error("red not lit in error state");
    a_fw_alt: assert property (s_fw_held |-> led_green != led_red)
        else $error("firmware lamps not alternating");
endmodule : sli_status_led_monitor

/* File: test/sli_led_model.sv */
// Purpose: Behavioural green and red lamps that count their light-ups.
// Assumes: Lamp drives are registered on mclk.
// Notes: Counts wrap at 8 bits; bench windows stay well below that.
module sli_led_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic led_green,
    input wire logic led_red,
    output logic [7:0] g_cnt,
    output logic [7:0] r_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic g_q, r_q;
    // A light-up is a rising edge of a lamp drive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            g_q <= 1'b0;
            r_q <= 1'b0;
            g_cnt <= 8'h00;
            r_cnt <= 8'h00;
        end else begin
            g_q <= led_green;
            r_q <= led_red;
            g_cnt <= clr ? 8'h00 : g_cnt + 8'(led_green && !g_q);
            r_cnt <= clr ? 8'h00 : r_cnt + 8'(led_red && !r_q);
        end
    end
endmodule : sli_led_model

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the status indicator block.
// Assumes: Short tick and blink parameters keep the run brief.
// Notes: Motion green blink counts allow one edge of phase slack at window ends; the burst count is exact.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, speed = 16'h0000, torque = 16'h0000;
    logic [15:0] status_bits = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, irq, motor_on = 1'b0, nv_write = 1'b0, fw_mode = 1'b0;
    logic [7:0] mode = 8'h00, g_cnt, r_cnt;
    logic led_green, led_red, clr = 1'b0, fw_done = 1'b0;
    int failures = 0, checked = 0;
    // Free-running 50 MHz clock
    always #10 mclk = ~mclk;
    // Burst and flash times shortened; firmware pace and speed scaling keep their defaults
    sli_status_led #(.TICK_CYC(TK), .ON_T(2), .OFF_T(2), .PAUSE_T(6), .FLASH_T(3)) DUT (
        .mclk(mclk),
        .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .motor_on(motor_on), .speed(speed), .torque(torque), .mode(mode),
        .nv_write(nv_write), .fw_mode(fw_mode), .fw_done(fw_done),
        .status_bits(status_bits), .led_green(led_green), .led_red(led_red));
    sli_led_model u_led (.mclk(mclk), .rst_n(rst_n), .clr(clr), .led_green(led_green),
        .led_red(led_red), .g_cnt(g_cnt), .r_cnt(r_cnt));
    // ==========================================================
    // Tasks
    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk_reg
    task automatic chk_cnt(input string n, input int lo, input int hi, input logic [7:0] g);
        checked++;
        if ($isunknown(g) || g < lo || g > hi) begin
            failures++;
            $display("MISMATCH %s exp %0d..%0d got %0d", n, lo, hi, g);
        end
    endtask : chk_cnt
    task automatic end_of_test;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
    endtask : rd_reg
    task automatic count_win(input int w);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        cyc(w);
        @(negedge mclk);
    endtask : count_win
    // ==========================================================
    // Main sequence
    initial begin
        logic [15:0] d;
        int n, w, q, half, s;
        void'($urandom(32'hdd56));
        cyc(16);
        rst_n <= 1'b1;
        rd_reg(sli_pkg::ADDR_ERR_EN, d);
        chk_reg("err_en", 16'h0000, d);
        rd_reg(sli_pkg::ADDR_IRQ_EN, d);
        chk_reg("irq_en", 16'h0000, d);
        rd_reg(4'hf, d);
        chk_reg("unmapped", 16'h0000, d);
        cyc(60);
        @(negedge mclk);
        chk_reg("idle", 16'h0001, {led_red, led_green});
        wr_reg(sli_pkg::ADDR_IRQ_EN, 16'h000f);
        // Store write then mode change, each a flash and an interrupt
        for (n = 0; n < 2; n++) begin
            nv_write <= (n == 0);
            mode <= (n == 0) ? mode : mode ^ 8'($urandom_range(255, 1));
            @(posedge mclk);
            nv_write <= 1'b0;
            cyc(2);
            @(negedge mclk);
            chk_reg("flash", 16'h0002, {led_red, led_green});
            rd_reg(sli_pkg::ADDR_IRQ_STAT, d);
            chk_reg("irq_stat", (n == 0) ? 16'h0004 : 16'h0002, d);
            chk_reg("irq", 16'h0001, 16'(irq));
            wr_reg(sli_pkg::ADDR_IRQ_CLR, 16'h000f);
            cyc(2);
            chk_reg("irq clr", 16'h0000, 16'(irq));
            cyc(60);
        end
        // Motion: slow, slow with high torque, fast
        motor_on <= 1'b1;
        for (n = 0; n < 3; n++) begin
            // Slow speed lands mid-range; full speed must hit the visible floor
            s = (n == 2) ? 16'hffff : 16'h6400;
            speed <= 16'(s);
            torque <= (n == 1) ? 16'hffff : 16'h0001;
            cyc(10);
            half = sli_pkg::SPD_BASE_MS - (s >> sli_pkg::SPD_SHIFT);
            half = (half < sli_pkg::SPD_MIN_MS) ? sli_pkg::SPD_MIN_MS : half;
            q = 4000 / (2 * half * TK);
            count_win(4000);
            if (n != 1) chk_cnt("green blinks", q - 1, q + 1, g_cnt);
            chk_cnt("red blinks", (n == 1) ? 1 : 0, (n == 1) ? 255 : 0, r_cnt);
        end
        motor_on <= 1'b0;
        torque <= 16'h0000;
        speed <= 16'h0000;
        // Every status bit in turn names its cause
        wr_reg(sli_pkg::ADDR_ERR_EN, 16'hffff);
        for (n = 0; n < 16; n++) begin
            status_bits <= 16'h0001 << n;
            cyc(4);
            rd_reg(sli_pkg::ADDR_ERR_STAT, d);
            chk_reg("err_stat", 16'h8000 | 16'(n + 1), d);
            status_bits <= 16'h0000;
            cyc(4);
        end
        // Masked bit is ignored, lowest enabled bit wins; the last cause (16) stays latched
        wr_reg(sli_pkg::ADDR_ERR_EN, 16'hfffe);
        for (n = 1; n < 4; n += 2) begin
            status_bits <= 16'(n);
            cyc(4);
            rd_reg(sli_pkg::ADDR_ERR_STAT, d);
            chk_reg("err_mask", (n == 1) ? 16'h0010 : 16'h8002, d);
        end
        rd_reg(sli_pkg::ADDR_IRQ_STAT, d);
        chk_reg("irq_err", 16'h0001, d & 16'h0001);
        chk_reg("irq err", 16'h0001, 16'(irq));
        // Dropping every enable must silence a pending interrupt
        wr_reg(sli_pkg::ADDR_IRQ_EN, 16'h0000);
        cyc(2);
        chk_reg("irq masked", 16'h0000, 16'(irq));
        status_bits <= 16'h0000;
        cyc(4);
        // Count the blinks of one burst, starting inside a pause
        n = $urandom_range(15, 1);
        status_bits <= 16'h0001 << n;
        w = 0;
        q = 0;
        while (q < 35) begin
            @(negedge mclk);
            w++;
            q = led_green ? 0 : q + 1;
            if (w > 2000) begin
                failures++;
                end_of_test();
            end
        end
        count_win((n + 1) * 4 * TK + 6 * TK);
        chk_cnt("burst", n + 1, n + 1, g_cnt);
        chk_reg("err red", 16'h0001, 16'(led_red));
        // Firmware mode overrides the error display and holds until reset while fw_done stays low
        @(posedge mclk);
        fw_mode <= 1'b1;
        cyc(5);
        count_win(3 * sli_pkg::FW_MS * TK);
        chk_cnt("fw green", 1, 3, g_cnt);
        chk_cnt("fw red", 1, 3, r_cnt);
        status_bits <= 16'h0000;
        fw_mode <= 1'b0;
        cyc(3);
        rd_reg(sli_pkg::ADDR_ERR_STAT, d);
        chk_reg("fw held", 16'h4000, d & 16'h4000);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        rd_reg(sli_pkg::ADDR_ERR_STAT, d);
        chk_reg("fw exit", 16'h0000, d);
        // A completed upgrade leaves firmware display without a power cycle
        fw_mode <= 1'b1;
        @(posedge mclk);
        fw_mode <= 1'b0;
        cyc(2);
        rd_reg(sli_pkg::ADDR_ERR_STAT, d);
        chk_reg("fw again", 16'h4000, d);
        fw_done <= 1'b1;
        @(posedge mclk);
        fw_done <= 1'b0;
        cyc(2);
        rd_reg(sli_pkg::ADDR_ERR_STAT, d);
        chk_reg("fw done", 16'h0000, d);
        end_of_test();
    end
    // Guard against a hang
    initial begin
        #1500000;
        failures++;
        end_of_test();
    end
endmodule : tb_top

bind sli_status_led sli_status_led_monitor #(.TICK_CYC(TICK_CYC), .FLASH_T(FLASH_T)) u_mon (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .motor_on(motor_on), .mode(mode), .nv_write(nv_write),
    .fw_mode(fw_mode), .fw_done(fw_done), .status_bits(status_bits),
    .led_green(led_green), .led_red(led_red));
